// file: rtl/rsis_pkg.sv
// Package for the remote station information store: map, layouts, constants.
// Overview of operation
// - Reserved stations never report wire-break or other errors while unconnected.
// - In normal mode, non-reserved stations with a nonzero point count and no answer report wire-break errors.
// - Request bit 4 rising from 0 to 1 starts the commit to non-volatile memory.
// - Status bit 4 sets when the commit finishes; software polls it.
// - Station words are writable only in station-scan mode (switch 6 on, 7 off).
// - Normal mode (switch 6 off, power cycled) uses the stored station words.
// - Bit 15 marks a reserved station, e.g. 0x0904 versus 0x8904.
// - Point counts may be edited and given to unconnected stations.
// - Remote point numbers always follow local expansion block points.
// - Reserved stations keep their point numbers though nothing is connected.
// - One 16-bit word per station 1..64 at word offsets 0x20..0x5F.
// - Word layout: count b0-4, flags b8-13; bits 5-7 and 14 stay zero.
package rsis_pkg;
   // Word indices of the host visible word area; byte address is four times
   localparam logic [7:0]  IDX_NV_REQ      = 8'h1B;
   localparam logic [7:0]  IDX_NV_STAT     = 8'h1C;
   localparam logic [7:0]  IDX_IRQ_STAT    = 8'h10;
   localparam logic [7:0]  IDX_IRQ_CLR     = 8'h11;
   localparam logic [7:0]  IDX_IRQ_EN      = 8'h12;
   localparam logic [7:0]  IDX_MODE        = 8'h13;
   localparam logic [7:0]  IDX_EXP_POINTS  = 8'h14;
   localparam logic [7:0]  IDX_STN_FIRST   = 8'h20;
   localparam logic [7:0]  IDX_STN_LAST    = 8'h5F;
   localparam int          NUM_STATIONS    = 64;
   // Field positions
   localparam int          NV_BIT          = 4;
   localparam int          CNT_LSB         = 0;
   localparam int          CNT_W           = 5;
   localparam logic [15:0] STN_WRITE_MASK  = 16'hBF1F;
   localparam int          RES_BIT         = 15;
   // Reset values
   localparam logic [15:0] STN_RESET       = 16'h0000;
   localparam logic [15:0] REG_RESET       = 16'h0000;
   // Commit time in ns and cycles at 10 MHz
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          NV_COMMIT_NS    = 6400;
   localparam int          NV_COMMIT_CYC   = (NV_COMMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          IRQ_W           = 2;

   // APB request group
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } rsis_apb_req_t;

   // Commit engine handshake
   typedef struct packed {
      logic [5:0]  station;
      logic [15:0] word;
      logic        valid;
   } rsis_nv_word_t;

   typedef enum logic [2:0] {
      NV_IDLE = 3'b001,
      NV_COPY = 3'b010,
      NV_DONE = 3'b100
   } rsis_nv_state_t;
endpackage

// file: rtl/rsis_nv_commit.sv
// Commit engine: copies station words to non-volatile memory one by one.
`timescale 1ns/1ps
module rsis_nv_commit (
   input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   input  wire logic                    start_in,
   input  wire logic                    req_level_in,
   input  wire logic [15:0]             word_in,
   output logic      [5:0]              index_out,
   output rsis_pkg::rsis_nv_word_t      nv_out,
   output logic                         done_out,
   output logic                         finish_out
);
   import rsis_pkg::*;

   rsis_nv_state_t state;
   logic [15:0]    pace;

   // Walk the 64 words with a fixed pace per word
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state      <= NV_IDLE;
         pace       <= 16'h0000;
         index_out  <= 6'h00;
         nv_out     <= '0;
         done_out   <= 1'b0;
         finish_out <= 1'b0;
      end else begin
         finish_out   <= 1'b0;
         nv_out.valid <= 1'b0;
         case (state)
            NV_IDLE: begin
               if (start_in) begin
                  state     <= NV_COPY;
                  index_out <= 6'h00;
                  pace      <= 16'h0000;
                  done_out  <= 1'b0;
               end else if (!req_level_in) begin
                  done_out <= 1'b0;
               end
            end
            NV_COPY: begin
               if (pace == 16'(NV_COMMIT_CYC - 1)) begin
                  pace           <= 16'h0000;
                  nv_out.valid   <= 1'b1;
                  nv_out.station <= index_out;
                  nv_out.word    <= word_in;
                  if (index_out == 6'(NUM_STATIONS - 1)) begin
                     state <= NV_DONE;
                  end else begin
                     index_out <= index_out + 6'h01;
                  end
               end else begin
                  pace <= pace + 16'h0001;
               end
            end
            NV_DONE: begin
               done_out   <= 1'b1;
               finish_out <= 1'b1;
               state      <= NV_IDLE;
            end
            default: state <= NV_IDLE;
         endcase
      end
   end
endmodule

// file: rtl/rsis_top.sv
// Remote station information store with APB slave and link error gating.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module rsis_top (
   input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   input  wire logic                    psel_in,
   input  wire logic                    penable_in,
   input  wire logic                    pwrite_in,
   input  wire logic [11:0]             paddr_in,
   input  wire logic [31:0]             pwdata_in,
   output logic      [31:0]             prdata_out,
   output logic                         pready_out,
   output logic                         pslverr_out,
   input  wire logic                    sw6_scan_in,
   input  wire logic                    sw7_in,
   input  wire logic [63:0]             station_answer_in,
   output logic      [63:0]             station_error_out,
   output logic      [63:0]             station_reserved_out,
   output logic                         scan_mode_out,
   output rsis_pkg::rsis_nv_word_t      nv_write_out,
   output logic                         irq_out
);
   import rsis_pkg::*;

   // Station words
   logic [15:0]    stn_mem [0:NUM_STATIONS-1];
   logic [15:0]    nv_req;
   logic [15:0]    exp_points;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_en;
   logic           sw6_m, sw6_s, sw7_m, sw7_s;
   logic [63:0]    ans_m, ans_s;
   logic           mode_latched;
   logic [1:0]     settle;
   logic           req_prev;
   logic [5:0]     nv_index;
   logic           nv_done;
   logic           nv_finish;
   logic           nv_start;
   logic           access;
   logic           wr;
   logic [7:0]     idx;
   logic           idx_ok;
   logic           err_rise;
   logic [63:0]    next_error;

   // Word index from a byte address; unaligned upper bits ignored
   function automatic logic [7:0] word_index(input logic [11:0] a);
      return a[9:2];
   endfunction

   // Station slot from word index
   function automatic logic [5:0] slot(input logic [7:0] i);
      return 6'(i - IDX_STN_FIRST);
   endfunction

   assign access = psel_in && penable_in && !pready_out;
   assign wr     = access && pwrite_in;
   assign idx    = word_index(paddr_in);
   assign idx_ok = (paddr_in[11:10] == 2'b00) && (paddr_in[1:0] == 2'b00) && (
                   (idx >= IDX_STN_FIRST && idx <= IDX_STN_LAST) || idx == IDX_NV_REQ ||
                   idx == IDX_NV_STAT || idx == IDX_IRQ_STAT || idx == IDX_IRQ_CLR ||
                   idx == IDX_IRQ_EN || idx == IDX_MODE || idx == IDX_EXP_POINTS);

   // Pin synchronisers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sw6_m <= 1'b0;
         sw6_s <= 1'b0;
         sw7_m <= 1'b0;
         sw7_s <= 1'b0;
         ans_m <= 64'h0;
         ans_s <= 64'h0;
      end else begin
         sw6_m <= sw6_scan_in;
         sw6_s <= sw6_m;
         sw7_m <= sw7_in;
         sw7_s <= sw7_m;
         ans_m <= station_answer_in;
         ans_s <= ans_m;
      end
   end

   // Mode caught once after reset release, as at power-on; the settle shifter
   // waits two edges so the synchronisers hold pin levels, not their reset zeros
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         settle        <= 2'b00;
         mode_latched  <= 1'b0;
         scan_mode_out <= 1'b0;
      end else begin
         settle <= {settle[0], 1'b1};
         if (!mode_latched && settle[1]) begin
            mode_latched  <= 1'b1;
            scan_mode_out <= sw6_s && !sw7_s;
         end
      end
   end

   // Station word writes, scan mode only, prohibited bits forced to zero
   always_ff @(posedge clk_in) begin
      if (wr && scan_mode_out && idx >= IDX_STN_FIRST && idx <= IDX_STN_LAST) begin
         stn_mem[slot(idx)] <= pwdata_in[15:0] & STN_WRITE_MASK;
      end
   end

   // Request, expansion count and interrupt enable registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         nv_req     <= REG_RESET;
         exp_points <= REG_RESET;
         irq_en     <= '0;
      end else if (wr) begin
         if (idx == IDX_NV_REQ) nv_req <= pwdata_in[15:0];
         if (idx == IDX_EXP_POINTS) exp_points <= pwdata_in[15:0];
         if (idx == IDX_IRQ_EN) irq_en <= pwdata_in[IRQ_W-1:0];
      end
   end

   // Rising edge of request bit starts a commit
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) req_prev <= 1'b0;
      else           req_prev <= nv_req[NV_BIT];
   end
   assign nv_start = nv_req[NV_BIT] && !req_prev;

   rsis_nv_commit u_commit (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .start_in     (nv_start),
      .req_level_in (nv_req[NV_BIT]),
      .word_in      (stn_mem[nv_index]),
      .index_out    (nv_index),
      .nv_out       (nv_write_out),
      .done_out     (nv_done),
      .finish_out   (nv_finish)
   );

   // Link errors: no answer, nonzero point count and not reserved; reserved keeps points silently
   always_comb begin
      for (int i = 0; i < NUM_STATIONS; i++) begin
         next_error[i] = !ans_s[i] && (stn_mem[i][CNT_W-1:CNT_LSB] != 5'h00) &&
                         !stn_mem[i][RES_BIT];
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         station_error_out    <= 64'h0;
         station_reserved_out <= 64'h0;
      end else begin
         station_error_out <= mode_latched && !scan_mode_out ? next_error : 64'h0;
         for (int i = 0; i < NUM_STATIONS; i++) begin
            station_reserved_out[i] <= stn_mem[i][RES_BIT];
         end
      end
   end

   assign err_rise = |(next_error & ~station_error_out) && mode_latched && !scan_mode_out;

   // Sticky events: bit0 commit done, bit1 new station error; set beats clear
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~((wr && idx == IDX_IRQ_CLR) ? pwdata_in[IRQ_W-1:0] : 2'b00))
                     | {err_rise, nv_finish};
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) irq_out <= 1'b0;
      else           irq_out <= |(irq_stat & irq_en);
   end

   // APB answer: one wait state, error on unmapped word
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0;
      end else begin
         pready_out  <= access;
         pslverr_out <= access && !idx_ok;
         prdata_out  <= 32'h0;
         if (access && !pwrite_in && idx_ok) begin
            if (idx >= IDX_STN_FIRST && idx <= IDX_STN_LAST)
               prdata_out <= {16'h0, stn_mem[slot(idx)]};
            else if (idx == IDX_NV_REQ)
               prdata_out <= {16'h0, nv_req};
            else if (idx == IDX_NV_STAT)
               prdata_out <= {16'h0, 11'h0, nv_done, 4'h0};
            else if (idx == IDX_IRQ_STAT)
               prdata_out <= {30'h0, irq_stat};
            else if (idx == IDX_IRQ_EN)
               prdata_out <= {30'h0, irq_en};
            else if (idx == IDX_MODE)
               prdata_out <= {29'h0, sw7_s, mode_latched, scan_mode_out};
            else if (idx == IDX_EXP_POINTS)
               prdata_out <= {16'h0, exp_points};
         end
      end
   end
endmodule

// file: test/rsis_top_props.sv
// Port checker for the station information store.
`timescale 1ns/1ps
module rsis_top_props (
   input wire logic                   clk_in,
   input wire logic                   rst_n_in,
   input wire logic                   psel_in,
   input wire logic                   penable_in,
   input wire logic [31:0]            prdata_out,
   input wire logic                   pready_out,
   input wire logic                   pslverr_out,
   input wire logic [63:0]            station_error_out,
   input wire logic [63:0]            station_reserved_out,
   input wire logic                   scan_mode_out,
   input wire rsis_pkg::rsis_nv_word_t nv_write_out
);
   import rsis_pkg::*;
   // One clock domain
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Bus answer timing and read data
   take_ready_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
      else $error("no answer");
   ready_one_a: assert property (pready_out |=> !pready_out) else $error("long ready");
   err_ready_a: assert property (pslverr_out |-> pready_out) else $error("lone error");
   rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("stale data");
   // Error gating and commit pacing
   res_quiet_a: assert property ((station_error_out & station_reserved_out) == 64'h0)
      else $error("reserved error");
   scan_quiet_a: assert property (scan_mode_out && $past(scan_mode_out)
      |-> station_error_out == 64'h0) else $error("error in scan");
   nv_gap_a: assert property (nv_write_out.valid |=> (!nv_write_out.valid) [*8])
      else $error("words too close");
   nv_next_a: assert property (nv_write_out.valid && nv_write_out.station != 6'h3F
      |-> ##[1:70] nv_write_out.valid) else $error("word missing");
   // Main scenarios seen
   cover property (pslverr_out);
   cover property (nv_write_out.valid);
   cover property (station_error_out != 64'h0);
endmodule
bind rsis_top rsis_top_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
   .penable_in(penable_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .station_error_out(station_error_out),
   .station_reserved_out(station_reserved_out), .scan_mode_out(scan_mode_out),
   .nv_write_out(nv_write_out));

// file: test/rsis_station_model.sv
// Remote stations on the field network.
`timescale 1ns/1ps
module rsis_station_model (
   input  wire logic        clk_in,
   input  wire logic [63:0] connected_in,
   output logic      [63:0] answer_out
);
   // A plugged station answers; an absent one stays silent
   always_ff @(posedge clk_in) begin
      answer_out <= connected_in;
   end
endmodule

// file: test/rsis_top_tb.sv
// Self-checking bench of the station information store.
`timescale 1ns/1ps
module rsis_top_tb;
   import rsis_pkg::*;
   logic          clk_in = 1'b0;
   logic          rst_n_in = 1'b0;
   logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sw6 = 1'b1, sw7 = 1'b0;
   logic          pready, pslverr, scan, irq, err;
   logic [11:0]   paddr = 12'h000;
   logic [15:0]   nv_first = 16'h0000;
   logic [31:0]   pwdata = 32'h0, prdata;
   logic [63:0]   conn = 64'h0, answer, serr, sres, rd;
   rsis_nv_word_t nvw;
   int            num_errors = 0, comparisons = 0, nv_count = 0;
   // Clock
   initial forever #50 clk_in = ~clk_in;
   // Design and far side
   rsis_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .sw6_scan_in(sw6), .sw7_in(sw7),
      .station_answer_in(answer), .station_error_out(serr), .station_reserved_out(sres),
      .scan_mode_out(scan), .nv_write_out(nvw), .irq_out(irq));
   rsis_station_model u_far (.clk_in(clk_in), .connected_in(conn), .answer_out(answer));
   // Count committed words and keep the word committed for station 1
   always @(posedge clk_in) begin
      if (nvw.valid === 1'b1) nv_count <= nv_count + 1;
      if (nvw.valid === 1'b1 && nvw.station === 6'h00) nv_first <= nvw.word;
   end
   // Verdict
   task automatic finish_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Compare
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // One clock of a bounded wait
   task automatic tick(inout int n, input int lim);
      @(posedge clk_in);
      n++;
      if (n >= lim) begin
         num_errors++;
         finish_test();
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do tick(n, 20);
      while (pready !== 1'b1);
      rd = 64'(prdata);
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reset with given switch settings
   task automatic reset(input logic s6, input logic s7);
      rst_n_in <= 1'b0;
      sw6 <= s6;
      sw7 <= s7;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (10) @(posedge clk_in);
   endtask
   // Scan mode edits, reserved flag, forced-zero bits, unmapped access
   task automatic t_scan();
      for (int i = 0; i < 64; i++) apb(1'b1, 12'h080 + 12'(i * 4), 32'h0);
      apb(1'b0, 12'h04C, 32'h0);
      chk(rd, 64'h3);
      apb(1'b1, 12'h080, 32'h0904);
      apb(1'b1, 12'h094, 32'h8904);
      apb(1'b1, 12'h17C, 32'hFFFF);
      apb(1'b0, 12'h094, 32'h0);
      chk(rd, 64'h8904);
      apb(1'b0, 12'h17C, 32'h0);
      chk(rd, 64'hBF1F);
      apb(1'b1, 12'h050, 32'h0020);
      apb(1'b0, 12'h050, 32'h0);
      chk(rd, 64'h20);
      chk(sres, 64'h8000000000000020);
      apb(1'b0, 12'hFFC, 32'h0);
      chk(64'(err), 64'h1);
   endtask
   // Commit, completion flag, interrupt mask and clear
   task automatic t_commit();
      int n = 0;
      int base;
      apb(1'b1, 12'h048, 32'h1);
      base = nv_count;
      apb(1'b1, 12'h06C, 32'h10);
      do tick(n, 6000);
      while (irq !== 1'b1);
      chk(64'(nv_count - base), 64'h40);
      chk(64'(nv_first), 64'h0904);
      apb(1'b0, 12'h070, 32'h0);
      chk(rd, 64'h10);
      apb(1'b0, 12'h040, 32'h0);
      chk(rd, 64'h1);
      apb(1'b1, 12'h048, 32'h0);
      @(posedge clk_in);
      chk(64'(irq), 64'h0);
      apb(1'b1, 12'h048, 32'h1);
      apb(1'b1, 12'h044, 32'h1);
      @(posedge clk_in);
      chk(64'(irq), 64'h0);
      apb(1'b1, 12'h06C, 32'h0);
      apb(1'b0, 12'h070, 32'h0);
      chk(rd, 64'h0);
   endtask
   // Normal mode: stored words, error gating by reserved flag and answer
   task automatic t_normal();
      reset(1'b0, 1'b1);
      apb(1'b0, 12'h04C, 32'h0);
      chk(rd, 64'h6);
      apb(1'b1, 12'h080, 32'h0);
      apb(1'b0, 12'h080, 32'h0);
      chk(rd, 64'h0904);
      chk(serr, 64'h1);
      conn <= 64'h1;
      repeat (8) @(posedge clk_in);
      chk(serr, 64'h0);
   endtask
   // Main sequence
   initial begin
      reset(1'b1, 1'b0);
      t_scan();
      t_commit();
      t_normal();
      finish_test();
   end
endmodule
